// ===== logic/byte_sync.sv
// Toggle synchroniser bringing link bytes into the system clock domain.
// Assumes at most one toggle per three system clocks.
`timescale 1ns/10ps
module byte_sync (
    input wire logic i_mclk,
    input wire logic i_srst,
    byte_xfer_if.dst xfer,
    output logic o_valid,
    output logic [7:0] o_data
);
    logic tgl_meta_r;
    logic tgl_sync_r;
    logic tgl_prev_r;
    wire tgl_edge = tgl_sync_r ^ tgl_prev_r;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            tgl_meta_r <= 1'b0;
            tgl_sync_r <= 1'b0;
            tgl_prev_r <= 1'b0;
            o_valid <= 1'b0;
            o_data <= 8'h00;
        end else begin
            tgl_meta_r <= xfer.toggle;
            tgl_sync_r <= tgl_meta_r;
            tgl_prev_r <= tgl_sync_r;
            o_valid <= tgl_edge;
            if (tgl_edge) begin
                o_data <= xfer.data;
            end
        end
    end
endmodule : byte_sync

// ===== logic/byte_xfer_if.sv
// Byte hand-off carrier from the link clock domain to the system clock domain.
// Assumes data stays stable for at least three system clocks after each toggle.
`timescale 1ns/10ps
interface byte_xfer_if;
    logic [7:0] data;
    logic toggle;
    modport src (output data, output toggle);
    modport dst (input data, input toggle);
endinterface : byte_xfer_if

// ===== logic/cfg_mode_pkg.sv
// Constants, types and decode helpers for the configuration mode selector.
// Assumes a 50 MHz system clock and an APB register port with 8-bit addresses.
package cfg_mode_pkg;

    // ==========================================================
    // Register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FRAME_LEN = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_BYTE_CNT = 8'h0c;
    localparam logic [7:0] OFS_LAST_BYTE = 8'h10;

    // ==========================================================
    // Field positions and reset values
    localparam int CTRL_LOAD_EN_BIT = 0;
    localparam int CTRL_DONE_BIT = 1;
    localparam int CTRL_RESTART_BIT = 2;
    localparam logic CTRL_LOAD_EN_RST = 1'h1;
    localparam logic [15:0] FRAME_LEN_RST = 16'h0020;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_PULLUP_BIT = 4;
    localparam int STAT_STATE_LSB = 8;
    localparam int STAT_FRAMES_LSB = 16;

    // ==========================================================
    // Timing
    localparam int MCLK_PERIOD_NS = 20;
    localparam int CONFIGURATION_CLOCK_HALF_NS = 80;
    localparam int CONFIGURATION_CLOCK_HALF_CYC = (CONFIGURATION_CLOCK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    // ==========================================================
    // Modes and states
    typedef enum logic [3:0] {
        MODE_MASTER_SERIAL = 4'b0001,
        MODE_SLAVE_PARALLEL = 4'b0010,
        MODE_BSCAN = 4'b0100,
        MODE_SLAVE_SERIAL = 4'b1000
    } cfg_mode_t;

    typedef enum logic [2:0] {
        ST_CLEAR = 3'b001,
        ST_LOAD = 3'b010,
        ST_DONE = 3'b100
    } load_state_t;

    // Pins given as {high, mid, low}
    function automatic cfg_mode_t decode_mode(input logic [2:0] pins);
        cfg_mode_t m;
        case (pins[1:0])
            2'b00: m = MODE_MASTER_SERIAL;
            2'b10: m = MODE_SLAVE_PARALLEL;
            2'b01: m = MODE_BSCAN;
            default: m = MODE_SLAVE_SERIAL;
        endcase
        return m;
    endfunction : decode_mode

    // Master serial pulls up on high pin set, the others on high pin clear
    function automatic logic decode_pullup(input logic [2:0] pins);
        return (pins[1:0] == 2'b00) ? pins[2] : ~pins[2];
    endfunction : decode_pullup

endpackage : cfg_mode_pkg

// ===== logic/config_mode_select.sv
// Configuration mode selector: mode pin capture, link control, byte stream.
// Assumes an APB master on i_mclk and a configuration clock pin fed back in.
//
// Contract
// - Pins low=0 mid=0 select master serial: clock out, 1-bit, pass-through on.
// - Pins low=1 mid=0 select boundary scan: clock unused, 1-bit, no pass-through.
// - Pins low=1 mid=1 select slave serial: clock in, 1-bit, pass-through on.
// - High pin picks user pull-ups or floating until configuration completes.
// - Test access port bytes are accepted while loading, whatever the mode pins say.
// - Boundary scan mode shuts the serial and parallel paths.
// - Each mode pin has a pull-up; an undriven pin reads high.
// - Source sends concatenated frames; device loads them one after another.
// - Mode pins are captured when the init indicator rises.
// - Serial modes move one bit per clock, MSB of each byte first.
`timescale 1ns/10ps
module config_mode_select #(
    parameter int CLK_HALF_CYC = cfg_mode_pkg::CONFIGURATION_CLOCK_HALF_CYC
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_srst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [cfg_mode_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Mode pins and init indicator
    input wire logic i_mode_pin_low,
    input wire logic i_mode_pin_mid,
    input wire logic i_mode_pin_high,
    input wire logic [2:0] i_mode_pin_undriven,
    input wire logic i_init_indicator,
    // Configuration link
    input wire logic i_configuration_clock,
    output logic o_configuration_clock,
    output logic o_configuration_clock_oe,
    input wire logic i_serial_din,
    output logic o_serial_dout,
    output logic o_serial_dout_oe,
    input wire logic [7:0] i_parallel_data,
    input wire logic i_parallel_wr_n,
    // Test access port bytes
    input wire logic i_tap_cfg_valid,
    input wire logic [7:0] i_tap_cfg_byte,
    // Configuration stream and status
    output logic [7:0] o_cfg_byte,
    output logic o_cfg_byte_valid,
    output logic o_frame_done,
    output logic o_user_pullup_en,
    output logic [3:0] o_mode,
    output logic o_wide_data
);
    import cfg_mode_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [3:0] pin_meta_r;
    logic [3:0] pin_sync_r;
    logic init_prev_r;
    wire [2:0] pins_raw = {i_mode_pin_high, i_mode_pin_mid, i_mode_pin_low} |
        i_mode_pin_undriven;
    wire [2:0] pins_s = pin_sync_r[2:0];
    wire init_s = pin_sync_r[3];
    wire init_rise = init_s && !init_prev_r;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            pin_meta_r <= 4'h7;
            pin_sync_r <= 4'h7;
            init_prev_r <= 1'b1;
        end else begin
            pin_meta_r <= {i_init_indicator, pins_raw};
            pin_sync_r <= pin_meta_r;
            init_prev_r <= init_s;
        end
    end

    // ==========================================================
    // Register decode
    logic load_en_r;
    logic [15:0] frame_len_r;
    logic [15:0] byte_cnt_r;
    logic [15:0] frame_cnt_r;
    logic [7:0] last_byte_r;
    load_state_t state_r;
    load_state_t state_nxt;
    cfg_mode_t mode_r;
    logic pullup_r;

    wire setup = i_psel && !i_penable;
    wire wr_acc = i_psel && i_penable && i_pwrite;
    wire hit_ctrl = (i_paddr == OFS_CTRL);
    wire hit_flen = (i_paddr == OFS_FRAME_LEN);
    wire hit_stat = (i_paddr == OFS_STATUS);
    wire hit_bcnt = (i_paddr == OFS_BYTE_CNT);
    wire hit_last = (i_paddr == OFS_LAST_BYTE);
    wire hit_any = hit_ctrl || hit_flen || hit_stat || hit_bcnt || hit_last;
    wire wr_done = wr_acc && hit_ctrl && i_pwdata[CTRL_DONE_BIT];
    wire wr_restart = wr_acc && hit_ctrl && i_pwdata[CTRL_RESTART_BIT];

    wire [31:0] stat_word = ({28'h0000000, 4'(mode_r)} << STAT_MODE_LSB) |
        ({31'h00000000, pullup_r} << STAT_PULLUP_BIT) |
        ({29'h00000000, 3'(state_r)} << STAT_STATE_LSB) |
        ({16'h0000, frame_cnt_r} << STAT_FRAMES_LSB);
    wire [31:0] rd_word = hit_ctrl ? {31'h00000000, load_en_r} << CTRL_LOAD_EN_BIT :
        hit_flen ? {16'h0000, frame_len_r} :
        hit_stat ? stat_word :
        hit_bcnt ? {16'h0000, byte_cnt_r} :
        hit_last ? {24'h000000, last_byte_r} : 32'h00000000;

    assign o_pready = i_psel && i_penable;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else if (setup) begin
            o_prdata <= i_pwrite ? 32'h00000000 : rd_word;
            o_pslverr <= !hit_any;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            load_en_r <= CTRL_LOAD_EN_RST;
            frame_len_r <= FRAME_LEN_RST;
        end else if (wr_acc) begin
            if (hit_ctrl) begin
                load_en_r <= i_pwdata[CTRL_LOAD_EN_BIT];
            end
            if (hit_flen) begin
                frame_len_r <= i_pwdata[15:0];
            end
        end
    end

    // ==========================================================
    // Load sequence and mode capture
    wire new_cycle = wr_restart || (!init_s && (state_r != ST_CLEAR));
    wire capture = (state_r == ST_CLEAR) && init_rise;
    wire st_load = (state_r == ST_LOAD);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_CLEAR: begin
                if (init_rise) begin
                    state_nxt = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (new_cycle) begin
                    state_nxt = ST_CLEAR;
                end else if (wr_done) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                if (new_cycle) begin
                    state_nxt = ST_CLEAR;
                end
            end
            default: state_nxt = ST_CLEAR;
        endcase
    end

    // Mode changes only at the capture edge
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            state_r <= ST_CLEAR;
            mode_r <= MODE_SLAVE_SERIAL;
            pullup_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (capture) begin
                mode_r <= decode_mode(pins_s);
                pullup_r <= decode_pullup(pins_s);
            end
        end
    end

    // ==========================================================
    // Mode effects on the pins
    wire is_master = (mode_r == MODE_MASTER_SERIAL);
    wire is_serial = is_master || (mode_r == MODE_SLAVE_SERIAL);
    wire is_par = (mode_r == MODE_SLAVE_PARALLEL);
    wire is_bscan = (mode_r == MODE_BSCAN);
    wire link_on = st_load && load_en_r && !is_bscan;
    logic serial_en_r;
    logic parallel_en_r;
    logic [7:0] div_cnt_r;
    wire div_wrap = (div_cnt_r == 8'(CLK_HALF_CYC - 1));

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            serial_en_r <= 1'b0;
            parallel_en_r <= 1'b0;
            o_serial_dout_oe <= 1'b0;
            o_configuration_clock_oe <= 1'b0;
            o_user_pullup_en <= 1'b0;
            o_mode <= 4'h0;
            o_wide_data <= 1'b0;
        end else begin
            serial_en_r <= link_on && is_serial;
            parallel_en_r <= link_on && is_par;
            o_serial_dout_oe <= is_serial;
            o_configuration_clock_oe <= is_master;
            o_user_pullup_en <= pullup_r && (state_r != ST_DONE);
            o_mode <= 4'(mode_r);
            o_wide_data <= is_par;
        end
    end

    // Master clock divider, idles low outside loading
    always_ff @(posedge i_mclk) begin
        if (i_srst || !(is_master && link_on)) begin
            div_cnt_r <= 8'h00;
            o_configuration_clock <= 1'b0;
        end else if (div_wrap) begin
            div_cnt_r <= 8'h00;
            o_configuration_clock <= ~o_configuration_clock;
        end else begin
            div_cnt_r <= div_cnt_r + 8'h01;
        end
    end

    // ==========================================================
    // Link domain and crossing
    byte_xfer_if xfer ();
    logic link_valid;
    logic [7:0] link_data;

    link_capture u_link (
        .i_link_clk(i_configuration_clock),
        .i_srst(i_srst),
        .i_serial_en(serial_en_r),
        .i_parallel_en(parallel_en_r),
        .i_serial_din(i_serial_din),
        .i_parallel_data(i_parallel_data),
        .i_parallel_wr_n(i_parallel_wr_n),
        .o_serial_dout(o_serial_dout),
        .xfer(xfer.src)
    );

    byte_sync u_sync (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .xfer(xfer.dst),
        .o_valid(link_valid),
        .o_data(link_data)
    );

    // ==========================================================
    // Byte stream and frame counting
    logic pend_r;
    logic [7:0] pend_data_r;
    wire tap_take = st_load && i_tap_cfg_valid;
    wire link_have = (link_valid || pend_r) && st_load && !is_bscan;
    wire link_take = link_have && !tap_take;
    wire [7:0] link_sel = pend_r ? pend_data_r : link_data;
    wire [7:0] byte_sel = tap_take ? i_tap_cfg_byte : link_sel;
    wire take = tap_take || link_take;
    wire frame_end = take && (byte_cnt_r == frame_len_r - 16'h0001);

    always_ff @(posedge i_mclk) begin
        if (i_srst || !st_load) begin
            pend_r <= 1'b0;
            pend_data_r <= 8'h00;
        end else if (link_valid && tap_take) begin
            pend_r <= 1'b1;
            pend_data_r <= link_data;
        end else if (link_take) begin
            pend_r <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst || capture) begin
            byte_cnt_r <= 16'h0000;
            frame_cnt_r <= 16'h0000;
        end else if (frame_end) begin
            byte_cnt_r <= 16'h0000;
            frame_cnt_r <= frame_cnt_r + 16'h0001;
        end else if (take) begin
            byte_cnt_r <= byte_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_cfg_byte <= 8'h00;
            o_cfg_byte_valid <= 1'b0;
            o_frame_done <= 1'b0;
            last_byte_r <= 8'h00;
        end else begin
            o_cfg_byte_valid <= take;
            o_frame_done <= frame_end;
            if (take) begin
                o_cfg_byte <= byte_sel;
                last_byte_r <= byte_sel;
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);

    a_mode_capture: assert property (capture |=> mode_r == decode_mode($past(pins_s)))
        else $error("Mode not captured at init rise");
    a_mode_hold: assert property (!capture |=> $stable(mode_r))
        else $error("Mode changed without capture");
    a_master_clock_out: assert property (is_master |=> o_configuration_clock_oe)
        else $error("Master serial not driving the clock");
    a_parallel_wide: assert property (is_par |=> o_wide_data && !o_serial_dout_oe)
        else $error("Slave parallel width or pass-through wrong");
    a_bscan_clock_off: assert property (is_bscan |=> !o_configuration_clock_oe)
        else $error("Boundary scan driving the clock");
    a_slave_serial_pins: assert property (
        (mode_r == MODE_SLAVE_SERIAL) |=> !o_configuration_clock_oe && o_serial_dout_oe)
        else $error("Slave serial pin directions wrong");
    a_pullup_apply: assert property (
        capture ##1 (state_r == ST_LOAD) |=> o_user_pullup_en == pullup_r)
        else $error("Pre-configuration pull-up choice not applied");
    a_tap_accept: assert property (tap_take |=> o_cfg_byte_valid &&
        o_cfg_byte == $past(i_tap_cfg_byte))
        else $error("Test access port byte dropped");
    a_bscan_paths_off: assert property (is_bscan |=> !serial_en_r && !parallel_en_r)
        else $error("Boundary scan left a link path open");
    a_pin_pullup: assert property ((&pins_raw)[*3] |=> pins_s == 3'h7)
        else $error("Undriven mode pins not read high");
    a_frame_wrap: assert property (frame_end |=> byte_cnt_r == 16'h0000 &&
        frame_cnt_r == $past(frame_cnt_r) + 16'h0001)
        else $error("Frame boundary not counted");

    c_master_capture: cover property (capture ##1 is_master);
    c_parallel_byte: cover property (is_par && link_take);
    c_tap_in_bscan: cover property (is_bscan && tap_take);
    c_frame_done: cover property (frame_end);

endmodule : config_mode_select

// ===== logic/link_capture.sv
// Link-side byte assembly on the configuration clock.
// Assumes enables and reset arrive from the system clock domain as levels.
`timescale 1ns/10ps
module link_capture (
    // Link clock and system-domain levels
    input wire logic i_link_clk,
    input wire logic i_srst,
    input wire logic i_serial_en,
    input wire logic i_parallel_en,
    // Pins
    input wire logic i_serial_din,
    input wire logic [7:0] i_parallel_data,
    input wire logic i_parallel_wr_n,
    output logic o_serial_dout,
    // Bytes out
    byte_xfer_if.src xfer
);
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic [6:0] shift_r;
    logic [2:0] bit_cnt_r;
    wire rst_l = sync_r[2];
    wire ser_en = sync_r[0];
    wire par_en = sync_r[1];
    wire byte_end = ser_en && (bit_cnt_r == 3'h7);
    wire par_take = par_en && !i_parallel_wr_n;

    always_ff @(posedge i_link_clk) begin
        meta_r <= {i_srst, i_parallel_en, i_serial_en};
        sync_r <= meta_r;
    end

    // MSB first, one bit per link clock
    always_ff @(posedge i_link_clk) begin
        if (rst_l || !ser_en) begin
            shift_r <= 7'h00;
            bit_cnt_r <= 3'h0;
        end else begin
            shift_r <= {shift_r[5:0], i_serial_din};
            bit_cnt_r <= bit_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (rst_l) begin
            xfer.data <= 8'h00;
            xfer.toggle <= 1'b0;
            o_serial_dout <= 1'b1;
        end else begin
            o_serial_dout <= ser_en ? i_serial_din : 1'b1;
            if (byte_end) begin
                xfer.data <= {shift_r, i_serial_din};
                xfer.toggle <= ~xfer.toggle;
            end else if (par_take) begin
                xfer.data <= i_parallel_data;
                xfer.toggle <= ~xfer.toggle;
            end
        end
    end

    a_serial_msb_first: assert property (@(posedge i_link_clk) disable iff (rst_l)
        byte_end |=> xfer.data[7] == $past(i_serial_din, 8))
        else $error("Serial byte not assembled MSB first");

endmodule : link_capture

// ===== verification/cfg_source_model.sv
// Behavioural configuration source on the far side of the link pins.
// Assumes the selector samples link data on rising link clock edges.
`timescale 1ns/10ps
module cfg_source_model (
    // Link pins
    output logic o_link_clk,
    output logic o_din,
    output logic [7:0] o_pdata,
    output logic o_wr_n
);
    initial begin
        o_link_clk = 1'b0;
        o_din = 1'b1;
        o_pdata = 8'h00;
        o_wr_n = 1'b1;
    end

    // ==========================================================
    // One 125 ns link cycle, data changed just after the falling edge
    task automatic tick(input logic bit_v);
        o_din = bit_v;
        #62.5 o_link_clk = 1'b1;
        #62.5 o_link_clk = 1'b0;
    endtask : tick

    // Short burst of idle clocks, clock stands still afterwards
    task automatic wake(input int n);
        for (int i = 0; i < n; i++) begin
            tick(1'b1);
        end
        o_din = 1'b0;
    endtask : wake

    // Frame bytes back to back, most significant bit first
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            tick(b[i]);
        end
        o_din = ~b[0];
    endtask : send_byte

    // One byte-wide write on a single link cycle, bus inverted afterwards
    task automatic send_par(input logic [7:0] b);
        o_pdata = b;
        o_wr_n = 1'b0;
        tick(1'b1);
        o_wr_n = 1'b1;
        o_pdata = ~b;
    endtask : send_par
endmodule : cfg_source_model

// ===== verification/tb_top.sv
// Self-checking bench for the configuration mode selector.
// Assumes the source model drives the link pins whenever the clock pin is an input.
`timescale 1ns/10ps
module tb_top;
    import cfg_mode_pkg::*;

    // ==========================================================
    // Signals
    logic mclk, srst, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] pins;
    logic [2:0] undriven;
    logic init, tap_valid, src_clk, src_din, src_wr_n, configuration_clock_out, configuration_clock_oe, dout, dout_oe;
    logic [7:0] tap_byte, cfg_byte, src_pdata;
    logic byte_valid, frame_done, pullup_en, wide;
    logic [3:0] mode;
    wire logic configuration_clock_pin;
    logic [8:0] exp_q[$];
    int failures = 0;
    int check_count = 0;
    int seed = 32'h634128b6;

    // Clock pin resolved from both drivers
    assign configuration_clock_pin = configuration_clock_oe ? configuration_clock_out : src_clk;

    config_mode_select i_config_mode_select (
        .i_mclk(mclk), .i_srst(srst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_mode_pin_low(pins[0]),
        .i_mode_pin_mid(pins[1]), .i_mode_pin_high(pins[2]), .i_mode_pin_undriven(undriven),
        .i_init_indicator(init), .i_configuration_clock(configuration_clock_pin),
        .o_configuration_clock(configuration_clock_out), .o_configuration_clock_oe(configuration_clock_oe),
        .i_serial_din(src_din), .o_serial_dout(dout), .o_serial_dout_oe(dout_oe),
        .i_parallel_data(src_pdata), .i_parallel_wr_n(src_wr_n),
        .i_tap_cfg_valid(tap_valid), .i_tap_cfg_byte(tap_byte), .o_cfg_byte(cfg_byte),
        .o_cfg_byte_valid(byte_valid), .o_frame_done(frame_done),
        .o_user_pullup_en(pullup_en), .o_mode(mode), .o_wide_data(wide)
    );

    cfg_source_model i_cfg_source_model (
        .o_link_clk(src_clk), .o_din(src_din), .o_pdata(src_pdata), .o_wr_n(src_wr_n)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out();
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // New configuration cycle: init low, pins set, init rises
    task automatic capture(input logic [2:0] p, input logic [2:0] u);
        @(posedge mclk);
        init <= 1'b0;
        repeat (4) @(posedge mclk);
        pins <= p;
        undriven <= u;
        repeat (3) @(posedge mclk);
        init <= 1'b1;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
    endtask : capture

    task automatic tap(input logic [7:0] b, input logic last);
        exp_q.push_back({last, b});
        @(posedge mclk);
        tap_valid <= 1'b1;
        tap_byte <= b;
        @(posedge mclk);
        tap_valid <= 1'b0;
        tap_byte <= ~b;
    endtask : tap

    task automatic drain();
        for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge mclk);
        chk(exp_q.size(), 0);
    endtask : drain

    // ==========================================================
    // Output watcher
    always @(negedge mclk) begin
        if (byte_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                chk({frame_done, cfg_byte}, exp_q.pop_front());
            end
        end
    end

    initial begin
        #1_000_000;
        failures++;
        close_out();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] rd;
        logic err, m0, m1, m2, pu, ck;
        logic [3:0] em;
        logic [7:0] b;
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pins = 3'b111;
        undriven = 3'b000;
        init = 1'b0;
        tap_valid = 1'b0;
        tap_byte = 8'h00;
        fork
            i_cfg_source_model.wake(4);
            repeat (5) @(posedge mclk);
        join
        @(posedge mclk);
        srst <= 1'b0;
        apb(1'b0, OFS_CTRL, 32'h0, rd, err);
        chk(rd, 32'h1);
        apb(1'b0, OFS_FRAME_LEN, 32'h0, rd, err);
        chk(rd, {16'h0, FRAME_LEN_RST});
        apb(1'b0, 8'h14, 32'h0, rd, err);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, OFS_FRAME_LEN, 32'h2, rd, err);
        // Loading off while modes are walked, so no link bits shift
        apb(1'b1, OFS_CTRL, 32'h0, rd, err);
        for (int i = 0; i < 9; i++) begin
            {m0, m1, m2} = (i == 8) ? 3'b111 : 3'(i);
            capture((i == 8) ? 3'b000 : {m2, m1, m0}, (i == 8) ? 3'b111 : 3'b000);
            em = 4'h1 << {m0, m1};
            pu = ({m0, m1} == 2'b00) ? m2 : ~m2;
            chk(mode, em);
            chk(pullup_en, pu);
            chk(configuration_clock_oe, em == 4'h1);
            chk(dout_oe, em == 4'h1 || em == 4'h8);
            chk(wide, em == 4'h2);
            chk(configuration_clock_out, 1'b0);
            apb(1'b0, OFS_STATUS, 32'h0, rd, err);
            chk(rd[4:0], {pu, em});
        end
        @(posedge mclk);
        undriven <= 3'b000;
        pins <= 3'b000;
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        chk(mode, 4'h8);
        apb(1'b1, OFS_CTRL, 32'h1, rd, err);
        i_cfg_source_model.wake(2);
        for (int k = 0; k < 2; k++) begin
            b = 8'($random(seed));
            exp_q.push_back({k[0], b});
            i_cfg_source_model.send_byte(b);
        end
        drain();
        chk(dout, b[0]);
        tap(8'($random(seed)), 1'b0);
        tap(8'($random(seed)), 1'b1);
        drain();
        capture(3'b010, 3'b000);
        i_cfg_source_model.wake(2);
        b = 8'($random(seed));
        exp_q.push_back({1'b0, b});
        i_cfg_source_model.send_par(b);
        drain();
        // Master serial runs its own clock once loading
        capture(3'b100, 3'b000);
        ck = configuration_clock_out;
        repeat (CONFIGURATION_CLOCK_HALF_CYC) @(negedge mclk);
        chk(configuration_clock_out, !ck);
        capture(3'b001, 3'b000);
        i_cfg_source_model.send_byte(8'($random(seed)));
        repeat (20) @(posedge mclk);
        tap(8'($random(seed)), 1'b0);
        drain();
        close_out();
    end
endmodule : tb_top
